//--- hw/sfa_pkg.sv
// sfa_pkg: shared constants and carrier types for the sample buffer
// block with auto-sleep; assumes a 100 MHz system clock.
package sfa_pkg;
  // clock and step timing
  localparam int CLK_KHZ = 100000;
  localparam int STEP_FAST_MS = 320;
  localparam int STEP_SLOW_MS = 640;
  localparam int STEP_FAST_CYC = STEP_FAST_MS * CLK_KHZ;
  localparam int STEP_SLOW_CYC = STEP_SLOW_MS * CLK_KHZ;
  // buffer geometry
  localparam int BUF_DEPTH = 32;
  localparam int CNT_W = 6;
  localparam int PTR_W = 5;
  localparam int DATA_W = 14;
  // register offsets
  localparam logic [7:0] ADR_READY = 8'h00;
  localparam logic [7:0] ADR_X_HIGH = 8'h01;
  localparam logic [7:0] ADR_X_LOW = 8'h02;
  localparam logic [7:0] ADR_Y_HIGH = 8'h03;
  localparam logic [7:0] ADR_Y_LOW = 8'h04;
  localparam logic [7:0] ADR_Z_HIGH = 8'h05;
  localparam logic [7:0] ADR_Z_LOW = 8'h06;
  localparam logic [7:0] ADR_BUF_SETUP = 8'h09;
  localparam logic [7:0] ADR_SYS_STATE = 8'h0B;
  localparam logic [7:0] ADR_INACT_LIMIT = 8'h29;
  localparam logic [7:0] ADR_MAIN_CTRL = 8'h2A;
  localparam logic [7:0] ADR_POWER_CTRL = 8'h2B;
  localparam logic [7:0] ADR_WAKE_CTRL = 8'h2C;
  localparam logic [7:0] ADR_EVENT_EN = 8'h2D;
  // buffer modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_CIRC = 2'h1;
  localparam logic [1:0] MODE_STOP = 2'h2;
  localparam logic [1:0] MODE_TRIG = 2'h3;
  // event bit layout: 7 sleep/wake, 6 buffer, 5 transient, 4 orientation,
  // 3 tap, 2 freefall/motion, 1 vector change, 0 data ready
  localparam logic [7:0] RESTART_MASK = 8'h7E;
  localparam logic [7:0] WAKE_MASK = 8'h3E;
  localparam int EV_SLEEP_WAKE = 7;
  localparam int EV_DATA_READY = 0;
  // control bit positions
  localparam int MAIN_ACTIVE = 0;
  localparam int MAIN_FAST_READ = 1;
  localparam int POWER_SLEEP_EN = 2;
  localparam int WAKE_BUF_GATE = 7;
  localparam logic [2:0] RATE_SLOWEST = 3'h7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] LAST_BYTE = 3'h5;

  typedef struct packed {
    logic [DATA_W-1:0] x;
    logic [DATA_W-1:0] y;
    logic [DATA_W-1:0] z;
  } sfa_sample_t;

  typedef struct packed {
    logic start;
    logic read;
    logic write;
    logic stop;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfa_regreq_t;

  typedef enum logic [1:0] {ST_STANDBY, ST_WAKE, ST_SLEEP} sfa_state_t;
endpackage

//--- hw/sfa_sample_buffer.sv
// sfa_sample_buffer: auto-sleep control, output data registers and the
// 32-sample buffer, with its byte register port. Assumes the serial port
// front end decodes transactions into regReq pulses on clk.
// Functional notes
// - limit sets least idle time before sleep, only with sleep enabled
// - one limit count is 320 ms, or 640 ms at the slowest active rate
// - an enabled restart event before the limit clears the sleep counter
// - reaching the limit with no restart event enters sleep rate
// - buffer restarts; sensing events restart and wake; sleep event neither
// - enabled wake event with its wake bit set returns to active rate
// - bypassed flags masked in sleep, restored on wake, except data ready
// - sleep/wake interrupt flags every transition in both directions
// - gate keeps contents, flags error, halts until host empties buffer
// - samples are 14-bit two's complement, left justified in two bytes
// - output registers show current sample, or buffer head when enabled
// - burst order X,Y,Z high then low; fast read skips low bytes
// - buffer enabled: 0x01 drains head, direct 0x02..0x06 read zero
// - ready status and six data registers form one incrementing range
// - mode: off, circular, stop when full, trigger
// - flush on disable, on sleep/wake rate change, on standby to active
// - writing mode off clears overflow, threshold flag and count
// - overflow flag set when count reaches 32
// - threshold flag while count at or above threshold; zero disables
// - samples enter at the current system rate
// - each buffer read returns and removes oldest, count minus one
// - burst ending mid-sample drops the rest of that sample
// - trigger mode circular pre-trigger, then fills and drops newest
`timescale 1ns/1ns
module sfa_sample_buffer #(
  parameter int STEP_FAST = sfa_pkg::STEP_FAST_CYC,
  parameter int STEP_SLOW = sfa_pkg::STEP_SLOW_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sampleClkPin,
  input wire sfa_pkg::sfa_sample_t sampleIn,
  input wire logic [7:0] eventIn,
  input wire logic trigEvent,
  input wire sfa_pkg::sfa_regreq_t regReq,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic sleepMode,
  output logic [2:0] sysRate,
  output logic sleepWakeIrq,
  output logic [7:0] eventEnEff
);
  import sfa_pkg::*;

  sfa_state_t state_reg, state_next;
  logic [2:0] tickSync_reg;
  logic tickLvl_reg, tickLvlOld_reg, sampleTick;
  logic [7:0] limit_reg, main_reg, power_reg, wake_reg, evEn_reg;
  logic [1:0] mode_reg;
  logic [5:0] wmrk_reg;
  logic [31:0] stepCnt_reg;
  logic [7:0] sleepCnt_reg;
  logic restartHit, wakeHit, goSleep, stepDone;
  logic [31:0] stepLen;
  sfa_sample_t buf_mem [BUF_DEPTH];
  sfa_sample_t cur_reg, head;
  logic [PTR_W-1:0] wrPtr_reg, rdPtr_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic ovf_reg, trigSeen_reg, gateHold_reg, fgerr_reg, ready_reg;
  logic push, pop, dropOld, flush, full, wmrkFlag;
  logic [7:0] ptr_reg, ptr_next, rdByte;
  logic [2:0] byteIdx_reg, byteIdx_next;
  logic bufRead, modeOffWr, activeRise;

  // register write decode
  function automatic logic wr(input logic [7:0] a);
    return regReq.write && ptr_reg == a;
  endfunction

  // byte of a sample, data left justified
  function automatic logic [7:0] byteOf(input sfa_sample_t s,
                                        input logic [2:0] idx);
    logic [DATA_W-1:0] v;
    v = (idx[2:1] == 2'h0) ? s.x : (idx[2:1] == 2'h1) ? s.y : s.z;
    return idx[0] ? {v[5:0], 2'h0} : v[13:6];
  endfunction

  // sample clock pin: three flops, change taken when last two agree
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      tickSync_reg <= 3'h0;
      tickLvl_reg <= 1'b0;
      tickLvlOld_reg <= 1'b0;
    end
    else
    begin
      tickSync_reg <= {tickSync_reg[1:0], sampleClkPin};
      if (tickSync_reg[1] == tickSync_reg[2])
        tickLvl_reg <= tickSync_reg[2];
      tickLvlOld_reg <= tickLvl_reg;
    end
  assign sampleTick = tickLvl_reg && !tickLvlOld_reg;

  // event qualification
  assign restartHit = |(eventIn & evEn_reg & RESTART_MASK);
  assign wakeHit = |(eventIn & evEn_reg & WAKE_MASK & wake_reg);
  assign stepLen = (main_reg[4:2] == RATE_SLOWEST) ?
    32'(STEP_SLOW) : 32'(STEP_FAST);
  assign stepDone = stepCnt_reg == stepLen - 32'h1;
  assign goSleep = power_reg[POWER_SLEEP_EN] && !restartHit
    && sleepCnt_reg == limit_reg;

  // inactivity step timer and counter
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      stepCnt_reg <= 32'h0;
      sleepCnt_reg <= 8'h0;
    end
    else if (state_reg != ST_WAKE || restartHit
             || !power_reg[POWER_SLEEP_EN])
    begin
      stepCnt_reg <= 32'h0;
      sleepCnt_reg <= 8'h0;
    end
    else if (stepDone)
    begin
      stepCnt_reg <= 32'h0;
      if (sleepCnt_reg != 8'hFF)
        sleepCnt_reg <= sleepCnt_reg + 8'h1;
    end
    else
      stepCnt_reg <= stepCnt_reg + 32'h1;

  // power state selection
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_STANDBY:
        if (main_reg[MAIN_ACTIVE])
          state_next = ST_WAKE;
      ST_WAKE:
        if (!main_reg[MAIN_ACTIVE])
          state_next = ST_STANDBY;
        else if (goSleep)
          state_next = ST_SLEEP;
      ST_SLEEP:
        if (!main_reg[MAIN_ACTIVE])
          state_next = ST_STANDBY;
        else if (wakeHit)
          state_next = ST_WAKE;
      default:
        state_next = ST_STANDBY;
    endcase
  end

  // power state, rate and effective enables
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      state_reg <= ST_STANDBY;
      sleepMode <= 1'b0;
      sysRate <= 3'h0;
      eventEnEff <= 8'h0;
    end
    else
    begin
      state_reg <= state_next;
      sleepMode <= state_next == ST_SLEEP;
      sysRate <= (state_next == ST_SLEEP) ? main_reg[7:5] : main_reg[4:2];
      eventEnEff <= (state_next == ST_SLEEP) ?
        (evEn_reg & (wake_reg | 8'h80)) : evEn_reg;
    end

  // sleep/wake interrupt flag, cleared by reading the state register
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      sleepWakeIrq <= 1'b0;
    else if (evEn_reg[EV_SLEEP_WAKE] && state_reg != ST_STANDBY
             && state_next != ST_STANDBY && state_next != state_reg)
      sleepWakeIrq <= 1'b1;
    else if (regReq.read && ptr_reg == ADR_SYS_STATE)
      sleepWakeIrq <= 1'b0;

  // control registers
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      limit_reg <= RESET_BYTE;
      main_reg <= RESET_BYTE;
      power_reg <= RESET_BYTE;
      wake_reg <= RESET_BYTE;
      evEn_reg <= RESET_BYTE;
      mode_reg <= MODE_OFF;
      wmrk_reg <= 6'h0;
    end
    else
    begin
      if (wr(ADR_INACT_LIMIT))
        limit_reg <= regReq.wdata;
      if (wr(ADR_MAIN_CTRL))
        main_reg <= regReq.wdata;
      if (wr(ADR_POWER_CTRL))
        power_reg <= regReq.wdata;
      if (wr(ADR_WAKE_CTRL))
        wake_reg <= regReq.wdata;
      if (wr(ADR_EVENT_EN))
        evEn_reg <= regReq.wdata;
      else if (state_reg == ST_WAKE && state_next == ST_SLEEP)
        evEn_reg[EV_DATA_READY] <= 1'b0;
      if (wr(ADR_BUF_SETUP))
      begin
        mode_reg <= regReq.wdata[7:6];
        wmrk_reg <= regReq.wdata[5:0];
      end
    end

  // buffer control terms
  assign head = buf_mem[rdPtr_reg];
  assign full = cnt_reg == CNT_W'(BUF_DEPTH);
  assign modeOffWr = wr(ADR_BUF_SETUP) && regReq.wdata[7:6] == MODE_OFF;
  assign activeRise = state_reg == ST_STANDBY && state_next == ST_WAKE;
  assign flush = modeOffWr || activeRise
    || (state_reg == ST_SLEEP && state_next == ST_WAKE && !gateHold_reg)
    || (state_reg == ST_WAKE && state_next == ST_SLEEP
        && !wake_reg[WAKE_BUF_GATE]);
  always_comb
  begin
    push = 1'b0;
    dropOld = 1'b0;
    if (sampleTick && mode_reg != MODE_OFF && state_reg != ST_STANDBY
        && !gateHold_reg)
      case (mode_reg)
        MODE_CIRC:
        begin
          push = 1'b1;
          dropOld = full;
        end
        MODE_STOP:
          push = !full;
        MODE_TRIG:
          if (trigSeen_reg)
            push = !full;
          else
          begin
            push = 1'b1;
            dropOld = full || (wmrk_reg != 6'h0
                               && cnt_reg >= CNT_W'(wmrk_reg));
          end
        default:
          push = 1'b0;
      endcase
  end
  assign bufRead = regReq.read && mode_reg != MODE_OFF
    && ptr_reg == ADR_X_HIGH;
  // pop after last byte, or at a burst end mid-sample
  assign pop = cnt_reg != CNT_W'(0) && !dropOld
    && ((bufRead && byteIdx_next == 3'h0)
        || (regReq.stop && byteIdx_reg != 3'h0));

  // buffer storage and pointers
  always_ff @(posedge clk)
    if (push)
      buf_mem[wrPtr_reg] <= sampleIn;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      cnt_reg <= '0;
    end
    else if (flush)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wrPtr_reg <= wrPtr_reg + PTR_W'(1);
      if (pop || dropOld)
        rdPtr_reg <= rdPtr_reg + PTR_W'(1);
      if (push && !dropOld && !pop)
        cnt_reg <= cnt_reg + CNT_W'(1);
      else if (pop && !push)
        cnt_reg <= cnt_reg - CNT_W'(1);
    end

  // overflow, trigger and gate flags
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      ovf_reg <= 1'b0;
      trigSeen_reg <= 1'b0;
      gateHold_reg <= 1'b0;
      fgerr_reg <= 1'b0;
    end
    else
    begin
      if (modeOffWr)
        ovf_reg <= 1'b0;
      else if (full)
        ovf_reg <= 1'b1;
      if (mode_reg == MODE_TRIG && trigEvent)
        trigSeen_reg <= 1'b1;
      else if (flush)
        trigSeen_reg <= 1'b0;
      if (state_reg == ST_WAKE && state_next == ST_SLEEP
          && wake_reg[WAKE_BUF_GATE])
      begin
        gateHold_reg <= 1'b1;
        fgerr_reg <= 1'b1;
      end
      else if (cnt_reg == CNT_W'(0))
      begin
        gateHold_reg <= 1'b0;
        fgerr_reg <= 1'b0;
      end
    end
  assign wmrkFlag = wmrk_reg != 6'h0 && cnt_reg >= CNT_W'(wmrk_reg);

  // current sample and ready status, set wins over read clear
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      cur_reg <= '0;
      ready_reg <= 1'b0;
    end
    else
    begin
      if (sampleTick && state_reg != ST_STANDBY)
        cur_reg <= sampleIn;
      if (sampleTick && state_reg != ST_STANDBY)
        ready_reg <= 1'b1;
      else if (regReq.read && ptr_reg == ADR_READY)
        ready_reg <= 1'b0;
    end

  // read data selection
  always_comb
  begin
    rdByte = 8'h0;
    case (ptr_reg)
      ADR_READY:
        rdByte = (mode_reg != MODE_OFF) ?
          {ovf_reg, wmrkFlag, cnt_reg} : {4'h0, ready_reg, 3'h0};
      ADR_X_HIGH, ADR_X_LOW, ADR_Y_HIGH, ADR_Y_LOW, ADR_Z_HIGH, ADR_Z_LOW:
        if (mode_reg == MODE_OFF)
          rdByte = byteOf(cur_reg, 3'(ptr_reg - ADR_X_HIGH));
        else if (ptr_reg == ADR_X_HIGH && cnt_reg != CNT_W'(0))
          rdByte = byteOf(head, byteIdx_reg);
        else
          rdByte = 8'h0;
      ADR_BUF_SETUP:
        rdByte = {mode_reg, wmrk_reg};
      ADR_SYS_STATE:
        rdByte = {fgerr_reg, 5'h0, 2'(state_reg)};
      ADR_INACT_LIMIT:
        rdByte = limit_reg;
      ADR_MAIN_CTRL:
        rdByte = main_reg;
      ADR_POWER_CTRL:
        rdByte = power_reg;
      ADR_WAKE_CTRL:
        rdByte = wake_reg;
      ADR_EVENT_EN:
        rdByte = evEn_reg;
      default:
        rdByte = 8'h0;
    endcase
  end

  // address auto-increment and byte position within a buffer sample
  always_comb
  begin
    ptr_next = ptr_reg + 8'h1;
    byteIdx_next = byteIdx_reg;
    if (bufRead)
    begin
      ptr_next = ptr_reg;
      byteIdx_next = byteIdx_reg + (main_reg[MAIN_FAST_READ] ? 3'h2 : 3'h1);
      if (byteIdx_next > LAST_BYTE)
        byteIdx_next = 3'h0;
    end
    else if (main_reg[MAIN_FAST_READ] && (ptr_reg == ADR_X_HIGH
             || ptr_reg == ADR_Y_HIGH || ptr_reg == ADR_Z_HIGH))
      ptr_next = ptr_reg + 8'h2;
  end

  // register port pointer and read answer
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      ptr_reg <= 8'h0;
      byteIdx_reg <= 3'h0;
      rdData <= 8'h0;
      rdValid <= 1'b0;
    end
    else
    begin
      rdValid <= regReq.read;
      if (regReq.read)
        rdData <= rdByte;
      if (regReq.start)
        ptr_reg <= regReq.addr;
      else if (regReq.read || regReq.write)
        ptr_reg <= ptr_next;
      if (regReq.stop || flush)
        byteIdx_reg <= 3'h0;
      else if (bufRead)
        byteIdx_reg <= byteIdx_next;
    end

  // checks
  sequence s_idle_limit;
    state_reg == ST_WAKE && main_reg[MAIN_ACTIVE] && goSleep;
  endsequence
  sequence s_wake_cause;
    state_reg == ST_SLEEP && main_reg[MAIN_ACTIVE] && wakeHit;
  endsequence
  a_sleep_entry: assert property (@(posedge clk) disable iff (!nrst)
    s_idle_limit |=> sleepMode && state_reg == ST_SLEEP)
    else $error("no sleep at inactivity limit");
  a_restart_clear: assert property (@(posedge clk) disable iff (!nrst)
    (state_reg == ST_WAKE && restartHit) |=> sleepCnt_reg == 8'h0
      && stepCnt_reg == 32'h0)
    else $error("restart event did not clear counter");
  a_wake_exit: assert property (@(posedge clk) disable iff (!nrst)
    s_wake_cause |=> !sleepMode ##1 sysRate == $past(main_reg[4:2], 2))
    else $error("wake event did not restore active rate");
  a_irq_transition: assert property (@(posedge clk)
    disable iff (!nrst)
    (s_idle_limit or s_wake_cause) ##0 evEn_reg[EV_SLEEP_WAKE]
      |=> sleepWakeIrq)
    else $error("transition raised no interrupt");
  a_mode_off_clear: assert property (@(posedge clk)
    disable iff (!nrst)
    modeOffWr |=> cnt_reg == CNT_W'(0) && !ovf_reg && !wmrkFlag)
    else $error("mode off did not clear status");
  a_ovf_full: assert property (@(posedge clk) disable iff (!nrst)
    (full && !modeOffWr) |=> ovf_reg)
    else $error("overflow flag missing at full count");
  a_pop_decrement: assert property (@(posedge clk)
    disable iff (!nrst)
    (pop && !push && !flush) |=> cnt_reg == $past(cnt_reg) - CNT_W'(1))
    else $error("buffer read did not decrement count");
  a_gate_hold: assert property (@(posedge clk) disable iff (!nrst)
    (state_reg == ST_WAKE && state_next == ST_SLEEP && wake_reg[WAKE_BUF_GATE]
      && cnt_reg != CNT_W'(0)) |=> fgerr_reg && gateHold_reg && !push
      && cnt_reg == $past(cnt_reg))
    else $error("gate did not hold buffer on sleep entry");
  a_direct_zero: assert property (@(posedge clk) disable iff (!nrst)
    (regReq.read && mode_reg != MODE_OFF && ptr_reg > ADR_X_HIGH
      && ptr_reg <= ADR_Z_LOW) |=> rdValid && rdData == 8'h0)
    else $error("direct low read not zero with buffer on");
endmodule

//--- verif/sfa_sample_src.sv
// sfa_sample_src: sensor front end model, makes sample ticks and data.
// assumes the bench raises run to stream samples at a 125 ns period.
`timescale 1ns/1ns
module sfa_sample_src (
  input wire logic run,
  output logic sampleClkPin,
  output sfa_pkg::sfa_sample_t sampleIn,
  output int sent
);
  import sfa_pkg::*;

  // pin idles low between bursts; data settles 62 ns before each tick
  initial
  begin
    sampleClkPin = 1'b0;
    sampleIn = '0;
    sent = 0;
    forever
    begin
      wait (run);
      sampleIn.x = {sent[7:0], 6'h15};
      sampleIn.y = {~sent[7:0], 6'h2A};
      sampleIn.z = {sent[7:0] ^ 8'hC3, 6'h3C};
      #62;
      sampleClkPin = 1'b1;
      sent = sent + 1;
      #63;
      sampleClkPin = 1'b0;
    end
  end
endmodule

//--- verif/tb.sv
// tb: register-level tests of the sample buffer with auto-sleep.
// assumes short step counts so a sleep timeout lasts tens of cycles.
`timescale 1ns/1ns
module tb;
  import sfa_pkg::*;
  localparam int SF = 20;
  localparam int SS = 40;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic trigEvent = 1'b0;
  logic run = 1'b0;
  logic [7:0] eventIn = 8'h00;
  sfa_regreq_t regReq = '0;
  logic [7:0] rdData;
  logic [7:0] eventEnEff;
  logic rdValid, sleepMode, sleepWakeIrq, sampleClkPin;
  logic [2:0] sysRate;
  sfa_sample_t sampleIn;
  int sent, k0, kb, c, st;
  int nFail = 0;
  int cmpCount = 0;
  int cyc = 0;
  logic [7:0] b [6];

  sfa_sample_buffer #(.STEP_FAST(SF), .STEP_SLOW(SS)) sfa_sample_buffer_i (
    .clk(clk), .nrst(nrst), .sampleClkPin(sampleClkPin),
    .sampleIn(sampleIn), .eventIn(eventIn), .trigEvent(trigEvent),
    .regReq(regReq), .rdData(rdData), .rdValid(rdValid),
    .sleepMode(sleepMode), .sysRate(sysRate),
    .sleepWakeIrq(sleepWakeIrq), .eventEnEff(eventEnEff));

  sfa_sample_src sfa_sample_src_i (
    .run(run), .sampleClkPin(sampleClkPin), .sampleIn(sampleIn),
    .sent(sent));

  // clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      nFail++;
      stopTest();
    end
  end

  // compare and count
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      $display("BAD %s exp %h seen %h", nm, exp, seen);
      nFail++;
    end
  endtask

  task stopTest;
    $display("compares %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one register port pulse, launched and dropped on rising edges
  task req(input logic s, r, w, p, input logic [7:0] a, d);
    @(posedge clk);
    regReq <= '{start:s, read:r, write:w, stop:p, addr:a, wdata:d};
    @(posedge clk);
    regReq <= '0;
    #1;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    req(1'b1, 1'b0, 1'b0, 1'b0, a, 8'h00);
    req(1'b0, 1'b0, 1'b1, 1'b0, 8'h00, d);
    req(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
  endtask

  // burst read of n bytes into b
  task rd(input logic [7:0] a, input int n);
    req(1'b1, 1'b0, 1'b0, 1'b0, a, 8'h00);
    for (int i = 0; i < n; i++)
    begin
      req(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
      chk("rdValid", {7'h00, rdValid}, 8'h01);
      b[i] = rdData;
    end
    req(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
  endtask

  // bytes of sample k as the model built it
  task chkSmp(input int k, input bit fast);
    logic [7:0] e [6];
    e = '{k[7:0], 8'h54, ~k[7:0], 8'hA8, k[7:0] ^ 8'hC3, 8'hF0};
    for (int i = 0; i < (fast ? 3 : 6); i++)
      chk("sampleByte", b[i], e[fast ? 2 * i : i]);
  endtask

  task send(input int n);
    k0 = sent;
    @(posedge clk);
    run <= 1'b1;
    wait (sent == k0 + n);
    @(posedge clk);
    run <= 1'b0;
    repeat (20) @(posedge clk);
  endtask

  task pulseEv(input logic [7:0] v);
    @(posedge clk);
    eventIn <= v;
    @(posedge clk);
    eventIn <= 8'h00;
    #1;
  endtask

  task waitSleep(input logic lvl, input int lim);
    c = 0;
    while (sleepMode !== lvl && c < lim)
    begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ADR_BUF_SETUP, 1);
    chk("setupReset", b[0], 8'h00);
    rd(8'h7F, 1);
    chk("unmapped", b[0], 8'h00);
    // direct sample registers, normal and fast burst
    wr(ADR_MAIN_CTRL, 8'h01);
    send(1);
    rd(ADR_X_HIGH, 6);
    chkSmp(k0, 1'b0);
    wr(ADR_MAIN_CTRL, 8'h03);
    rd(ADR_X_HIGH, 3);
    chkSmp(k0, 1'b1);
    rd(ADR_Z_LOW, 1);
    chk("directLow", b[0], 8'hF0);
    // stop-when-full, then circular; threshold set in standby
    for (int m = 0; m < 2; m++)
    begin
      wr(ADR_MAIN_CTRL, 8'h00);
      wr(ADR_BUF_SETUP, 8'h00);
      wr(ADR_BUF_SETUP, m ? 8'h44 : 8'h84);
      wr(ADR_MAIN_CTRL, 8'h01);
      send(5);
      kb = k0;
      rd(ADR_READY, 1);
      chk("count5", b[0], 8'h45);
      rd(ADR_X_LOW, 1);
      chk("lowZero", b[0], 8'h00);
      rd(ADR_X_HIGH, 6);
      chkSmp(kb, 1'b0);
      rd(ADR_X_HIGH, 2);
      rd(ADR_X_HIGH, 1);
      chk("nextX", b[0], kb[7:0] + 8'h02);
      rd(ADR_READY, 1);
      chk("count2", b[0], 8'h02);
      send(38);
      rd(ADR_READY, 1);
      chk("full", b[0], 8'hE0);
      rd(ADR_X_HIGH, 6);
      chkSmp(kb + (m ? 11 : 3), 1'b0);
    end
    // disabling clears count and flags
    wr(ADR_BUF_SETUP, 8'h04);
    wr(ADR_BUF_SETUP, 8'h44);
    rd(ADR_READY, 1);
    chk("cleared", b[0], 8'h00);
    wr(ADR_BUF_SETUP, 8'h00);
    // trigger mode: pre-trigger window, then fill and drop newest
    wr(ADR_MAIN_CTRL, 8'h00);
    wr(ADR_BUF_SETUP, 8'hC3);
    wr(ADR_MAIN_CTRL, 8'h01);
    send(5);
    kb = k0;
    rd(ADR_READY, 1);
    chk("preTrig", b[0], 8'h43);
    @(posedge clk);
    trigEvent <= 1'b1;
    @(posedge clk);
    trigEvent <= 1'b0;
    send(35);
    rd(ADR_READY, 1);
    chk("trigFull", b[0], 8'hE0);
    rd(ADR_X_HIGH, 6);
    chkSmp(kb + 2, 1'b0);
    wr(ADR_BUF_SETUP, 8'h00);
    // auto-sleep at a fast and at the slowest active rate
    wr(ADR_INACT_LIMIT, 8'h03);
    wr(ADR_POWER_CTRL, 8'h04);
    wr(ADR_WAKE_CTRL, 8'h20);
    for (int r = 0; r < 2; r++)
    begin
      st = r ? SS : SF;
      wr(ADR_EVENT_EN, 8'hE1);
      wr(ADR_MAIN_CTRL, 8'h00);
      wr(ADR_MAIN_CTRL, r ? 8'hBD : 8'hA9);
      repeat (6)
      begin
        repeat (st) @(posedge clk);
        pulseEv(8'h20);
      end
      chk("noSleep", {7'h00, sleepMode}, 8'h00);
      waitSleep(1'b1, 5 * st);
      c = (c > 2 * st && c <= 3 * st + 8);
      chk("sleepTime", c[7:0], 8'h01);
      repeat (2) @(posedge clk);
      #1;
      chk("sleepRate", {5'h00, sysRate}, 8'h05);
      chk("irqSleep", {7'h00, sleepWakeIrq}, 8'h01);
      chk("enSleep", eventEnEff, 8'hA0);
      rd(ADR_SYS_STATE, 1);
      chk("stateSleep", b[0], 8'h02);
      chk("irqClear", {7'h00, sleepWakeIrq}, 8'h00);
      pulseEv(8'h40);
      repeat (5) @(posedge clk);
      #1;
      chk("bufNoWake", {7'h00, sleepMode}, 8'h01);
      pulseEv(8'h20);
      waitSleep(1'b0, 10);
      repeat (2) @(posedge clk);
      #1;
      chk("woken", {7'h00, sleepMode}, 8'h00);
      chk("wakeRate", {5'h00, sysRate}, r ? 8'h07 : 8'h02);
      chk("irqWake", {7'h00, sleepWakeIrq}, 8'h01);
      chk("enWake", eventEnEff, 8'hE0);
      rd(ADR_EVENT_EN, 1);
      chk("enRestored", b[0], 8'hE0);
      rd(ADR_SYS_STATE, 1);
    end
    // buffer gate: contents kept through sleep, no pushes until drained
    wr(ADR_MAIN_CTRL, 8'h00);
    wr(ADR_BUF_SETUP, 8'h40);
    wr(ADR_WAKE_CTRL, 8'hA0);
    wr(ADR_MAIN_CTRL, 8'hA9);
    send(2);
    kb = k0;
    waitSleep(1'b1, 200);
    rd(ADR_SYS_STATE, 1);
    chk("gateErr", b[0], 8'h82);
    send(1);
    rd(ADR_READY, 1);
    chk("gateHeld", b[0], 8'h02);
    rd(ADR_X_HIGH, 6);
    chkSmp(kb, 1'b0);
    rd(ADR_X_HIGH, 6);
    rd(ADR_SYS_STATE, 1);
    chk("gateOpen", b[0], 8'h02);
    send(1);
    rd(ADR_READY, 1);
    chk("gateResume", b[0], 8'h01);
    stopTest();
  end
endmodule
